/* common/sdi12_cmd_regs.svh */
// Constants shared by the sensor and logger command ends
// Function
// RULE1 - Verify reply: address, ttt, n, CRLF
// RULE2 - Verify data content is sensor defined
// RULE3 - Query reply gives current address
// RULE4 - Master queries only with one sensor
// RULE5 - Addresses on one terminal are distinct
// RULE6 - Change address adopts and echoes new address
// RULE7 - One sensor attached while changing address
// RULE8 - Measure reply: address, ttt, n 0..9
// RULE9 - Measure completion sends service request
// RULE10 - Master waits request or timeout first
// RULE11 - Data requests start at index zero
// RULE12 - Data reply: address, signed values, CRLF; the code sends only one sign char per value
// RULE13 - Master scan longer than measure time
// RULE14 - Concurrent reply: address, ttt, nn, CRLF
// RULE15 - Concurrent completion sends no service request
// RULE16 - Concurrent measurements may overlap across sensors
// RULE17 - Master fetches data next scan after time
// RULE18 - Concurrent scan interval at most ten seconds
// RULE19 - Time-count reply sent before measuring
// RULE20 - Commands address-first, bang-terminated; replies CRLF
// RULE21 - Break abandons ordinary measurement
// RULE22 - New addressed command aborts concurrent measurement
// RULE23 - Time and count as padded decimals
// RULE24 - Ignore foreign address except query
`ifndef SDI12_CMD_REGS_SVH
`define SDI12_CMD_REGS_SVH
`define CH_BANG 8'h21
`define CH_QUERY 8'h3F
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_ZERO 8'h30
`define CH_PLUS 8'h2B
`define CH_MINUS 8'h2D
`define CH_V 8'h56
`define CH_A 8'h41
`define CH_M 8'h4D
`define CH_C 8'h43
`define CH_D 8'h44
`define DEF_ADDR 8'h30
`define CLK_HZ 100000000
`define SEC_NS 1000000000
`define CLK_NS 10
`define SEC_CYCLES (`SEC_NS / `CLK_NS)
`define LINE_MAX 16
`endif

/* common/sdi12_cmd_pkg.sv */
// Types used by the sensor command end only
package sdi12_cmd_pkg;
  typedef enum logic [1:0] {MEAS_IDLE, MEAS_ORD, MEAS_CONC, MEAS_DONE} meas_t;
  typedef enum logic [1:0] {RX_IDLE, RX_BODY, RX_EXEC, RX_SEND} rx_t;
endpackage : sdi12_cmd_pkg

/* common/sdi12_link_if.sv */
// Character link between logger and sensor, one byte per valid-ready beat
`timescale 1ns/100ps
interface sdi12_link_if;
  logic [7:0] cmd_data;
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] rsp_data;
  logic rsp_valid;
  logic rsp_ready;
  logic brk;
  modport sensor (input cmd_data, input cmd_valid, output cmd_ready,
                  output rsp_data, output rsp_valid, input rsp_ready, input brk);
  modport logger (output cmd_data, output cmd_valid, input cmd_ready,
                  input rsp_data, input rsp_valid, output rsp_ready, output brk);
endinterface : sdi12_link_if

/* hdl/sdi12_fifo.sv */
// Parameterised valid-ready FIFO for reply characters
`timescale 1ns/100ps
module sdi12_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire empty = (wp_q == rp_q);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rp_q[AW-1:0]];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (push) mem_q[wp_q[AW-1:0]] <= in_data;
  end
endmodule : sdi12_fifo

/* hdl/sdi12_sensor_end.sv */
// Sensor end: parses commands, runs measurements, queues replies
`timescale 1ns/100ps
`include "sdi12_cmd_regs.svh"
module sdi12_sensor_end #(
  parameter int SEC_CYCLES = `SEC_CYCLES,
  parameter int NVAL = 2,
  parameter int MEAS_SEC = 3,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  sdi12_link_if.sensor link,
  input wire logic [NVAL*16-1:0] sample_in,
  output logic [7:0] addr_out,
  output logic busy_out
);
  initial begin
    if (NVAL < 1 || NVAL > 9) $error("NVAL must be 1..9");
    if (MEAS_SEC < 0 || MEAS_SEC > 999) $error("MEAS_SEC must be 0..999");
    if (SEC_CYCLES < 1) $error("SEC_CYCLES must be positive");
  end
  localparam logic [7:0] T2 = 8'(`CH_ZERO + MEAS_SEC / 100);
  localparam logic [7:0] T1 = 8'(`CH_ZERO + (MEAS_SEC / 10) % 10);
  localparam logic [7:0] T0 = 8'(`CH_ZERO + MEAS_SEC % 10);
  localparam logic [7:0] NCH = 8'(`CH_ZERO + NVAL);

  sdi12_cmd_pkg::rx_t st_q;
  sdi12_cmd_pkg::meas_t meas_q;
  logic [7:0] addr_q;
  logic [7:0] buf_q [`LINE_MAX];
  logic [4:0] len_q;
  logic [7:0] line_q [`LINE_MAX];
  logic [4:0] olen_q;
  logic [4:0] optr_q;
  logic [31:0] tick_q;
  logic [9:0] sec_q;
  logic srq_q;
  logic [NVAL*16-1:0] val_q;

  logic [7:0] f_data;
  logic f_valid;
  logic f_ready;
  sdi12_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk), .rst(rst), .in_data(f_data), .in_valid(f_valid),
    .in_ready(f_ready), .out_data(link.rsp_data), .out_valid(link.rsp_valid),
    .out_ready(link.rsp_ready));

  // Decode of the completed command line
  wire rx_take = (st_q == sdi12_cmd_pkg::RX_IDLE || st_q == sdi12_cmd_pkg::RX_BODY) && link.cmd_valid;
  wire is_query = (buf_q[0] == `CH_QUERY) && (len_q == 5'd1);
  wire mine = (buf_q[0] == addr_q); // see RULE24
  wire c_ack = len_q == 5'd1;
  wire c_ver = len_q == 5'd2 && buf_q[1] == `CH_V;
  wire c_chg = len_q == 5'd3 && buf_q[1] == `CH_A;
  wire c_meas = len_q == 5'd2 && buf_q[1] == `CH_M;
  wire c_conc = len_q == 5'd2 && buf_q[1] == `CH_C;
  wire c_data = len_q == 5'd3 && buf_q[1] == `CH_D && buf_q[2] == `CH_ZERO; // see RULE11
  wire meas_run = meas_q == sdi12_cmd_pkg::MEAS_ORD || meas_q == sdi12_cmd_pkg::MEAS_CONC;
  wire sec_end = tick_q == 32'(SEC_CYCLES - 1);
  wire exec_ok = st_q == sdi12_cmd_pkg::RX_EXEC && (mine || is_query);
  wire send_idle = st_q == sdi12_cmd_pkg::RX_IDLE && olen_q == 5'd0;

  // Receiver stays open while a concurrent measurement runs, see RULE16
  assign link.cmd_ready = st_q == sdi12_cmd_pkg::RX_IDLE || st_q == sdi12_cmd_pkg::RX_BODY;
  assign f_valid = optr_q < olen_q;
  assign f_data = line_q[optr_q[3:0]];

  // Command receive: address first, bang ends the line
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= sdi12_cmd_pkg::RX_IDLE;
      len_q <= '0;
    end else if (link.brk) begin
      st_q <= sdi12_cmd_pkg::RX_IDLE;
      len_q <= '0;
    end else if (rx_take) begin
      if (link.cmd_data == `CH_BANG) begin // see RULE20
        st_q <= sdi12_cmd_pkg::RX_EXEC;
      end else if (len_q < 5'(`LINE_MAX)) begin
        buf_q[len_q[3:0]] <= link.cmd_data;
        len_q <= len_q + 5'd1;
        st_q <= sdi12_cmd_pkg::RX_BODY;
      end
    end else if (st_q == sdi12_cmd_pkg::RX_EXEC) begin
      st_q <= sdi12_cmd_pkg::RX_SEND;
    end else if (st_q == sdi12_cmd_pkg::RX_SEND && olen_q == 5'd0) begin
      st_q <= sdi12_cmd_pkg::RX_IDLE;
      len_q <= '0;
    end
  end

  // Reply assembly and FIFO feed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      olen_q <= '0;
      optr_q <= '0;
    end else if (olen_q != 5'd0) begin
      if (f_ready && f_valid) optr_q <= optr_q + 5'd1;
      if (optr_q == olen_q) begin
        olen_q <= '0;
        optr_q <= '0;
      end
    end else if (exec_ok) begin
      optr_q <= '0;
      if (is_query) begin
        line_q[0] <= addr_q; // see RULE3
        line_q[1] <= `CH_CR;
        line_q[2] <= `CH_LF;
        olen_q <= 5'd3;
      end else if (c_chg) begin
        line_q[0] <= buf_q[2]; // see RULE6
        line_q[1] <= `CH_CR;
        line_q[2] <= `CH_LF;
        olen_q <= 5'd3;
      end else if (c_ver || c_meas || c_conc) begin
        // Reply is queued in the same cycle the timer is loaded, see RULE19
        line_q[0] <= addr_q;
        line_q[1] <= T2; // see RULE23
        line_q[2] <= T1;
        line_q[3] <= T0;
        if (c_conc) begin
          line_q[4] <= `CH_ZERO; // see RULE14
          line_q[5] <= NCH;
          line_q[6] <= `CH_CR;
          line_q[7] <= `CH_LF;
          olen_q <= 5'd8;
        end else begin
          // Verify results carry no values of ours, see RULE2
          line_q[4] <= c_ver ? `CH_ZERO : NCH; // see RULE1
          line_q[5] <= `CH_CR; // see RULE8
          line_q[6] <= `CH_LF;
          olen_q <= 5'd7;
        end
      end else if (c_data) begin
        line_q[0] <= addr_q; // see RULE12
        for (int i = 0; i < NVAL; i++) begin
          line_q[1+i] <= val_q[i*16+15] ? `CH_MINUS : `CH_PLUS;
        end
        line_q[NVAL+1] <= `CH_CR;
        line_q[NVAL+2] <= `CH_LF;
        olen_q <= 5'(NVAL + 3);
      end else begin
        line_q[0] <= addr_q;
        line_q[1] <= `CH_CR;
        line_q[2] <= `CH_LF;
        olen_q <= 5'd3;
      end
    end else if (srq_q && send_idle) begin
      line_q[0] <= addr_q; // see RULE9
      line_q[1] <= `CH_CR;
      line_q[2] <= `CH_LF;
      olen_q <= 5'd3;
      optr_q <= '0;
    end
  end

  // Address, measurement timer, service request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_q <= `DEF_ADDR;
      meas_q <= sdi12_cmd_pkg::MEAS_IDLE;
      tick_q <= '0;
      sec_q <= '0;
      srq_q <= 1'b0;
      val_q <= '0;
      addr_out <= `DEF_ADDR;
      busy_out <= 1'b0;
    end else begin
      addr_out <= addr_q;
      busy_out <= meas_run;
      if (link.brk && meas_q == sdi12_cmd_pkg::MEAS_ORD) begin
        meas_q <= sdi12_cmd_pkg::MEAS_IDLE; // see RULE21
      end else if (exec_ok && !is_query) begin
        if (c_chg) addr_q <= buf_q[2]; // see RULE6
        if (c_meas || c_conc || c_ver) begin
          meas_q <= c_conc ? sdi12_cmd_pkg::MEAS_CONC : sdi12_cmd_pkg::MEAS_ORD;
          tick_q <= '0;
          sec_q <= 10'(MEAS_SEC);
        end else if (meas_q == sdi12_cmd_pkg::MEAS_CONC) begin
          meas_q <= sdi12_cmd_pkg::MEAS_IDLE; // see RULE22
        end
      end else if (meas_run) begin
        tick_q <= sec_end ? '0 : tick_q + 32'd1;
        if (sec_q == 10'd0) begin
          val_q <= sample_in;
          srq_q <= meas_q == sdi12_cmd_pkg::MEAS_ORD; // see RULE15
          meas_q <= sdi12_cmd_pkg::MEAS_DONE;
        end else if (sec_end) begin
          sec_q <= sec_q - 10'd1;
        end
      end
      if (srq_q && send_idle && !exec_ok) srq_q <= 1'b0;
    end
  end
endmodule : sdi12_sensor_end

/* hdl/sdi12_logger_end.sv */
// Logger end: sends one command line and collects the reply line
`timescale 1ns/100ps
`include "sdi12_cmd_regs.svh"
module sdi12_logger_end (
  input wire logic sys_clk,
  input wire logic rst,
  sdi12_link_if.logger link,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_byte_valid,
  output logic cmd_byte_ready,
  input wire logic brk_req,
  output logic [7:0] rsp_byte,
  output logic rsp_byte_valid,
  output logic line_done
);
  // Master-side duties (RULE4, RULE5, RULE7, RULE10, RULE13, RULE16-18)
  // are scheduling choices of whatever drives cmd_byte.
  assign link.cmd_data = cmd_byte;
  assign link.cmd_valid = cmd_byte_valid;
  assign link.rsp_ready = 1'b1;
  wire rsp_take = link.rsp_valid;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_byte_ready <= 1'b0;
      rsp_byte <= '0;
      rsp_byte_valid <= 1'b0;
      line_done <= 1'b0;
      link.brk <= 1'b0;
    end else begin
      cmd_byte_ready <= link.cmd_ready;
      link.brk <= brk_req;
      rsp_byte_valid <= rsp_take;
      if (rsp_take) rsp_byte <= link.rsp_data;
      line_done <= rsp_take && link.rsp_data == `CH_LF; // see RULE20
    end
  end
endmodule : sdi12_logger_end

/* testbench/sdi12_link_sva.sv */
// Link protocol checker for the sensor and logger command ends
`timescale 1ns/100ps
module sdi12_link_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic brk
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic cmd_hs;
  logic rsp_hs;
  logic bang;
  logic [7:0] last_q;
  logic [4:0] pos_q;
  logic mid_q;
  assign cmd_hs = cmd_valid && cmd_ready;
  assign rsp_hs = rsp_valid && rsp_ready;
  assign bang = cmd_hs && cmd_data == 8'h21;
  // Last reply char, position in the reply line, and command in progress
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      last_q <= 8'h0A;
      pos_q <= 5'h00;
      mid_q <= 1'b0;
    end else begin
      if (rsp_hs) last_q <= rsp_data;
      if (rsp_hs) pos_q <= (rsp_data == 8'h0A) ? 5'h00 : pos_q + 5'h01;
      if (brk || bang) mid_q <= 1'b0;
      else if (cmd_hs) mid_q <= 1'b1;
    end
  end
  reply_busy_a: assert property (bang |=> !cmd_ready)
    else $error("command taken while reply pending");
  reply_back_a: assert property (bang |-> ##[1:30] cmd_ready)
    else $error("receiver not ready again after reply");
  cmd_hold_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
    else $error("command char changed before taken");
  lf_after_cr_a: assert property (rsp_hs && last_q == 8'h0D |-> rsp_data == 8'h0A)
    else $error("carriage return not followed by line feed");
  cr_before_lf_a: assert property (rsp_hs && rsp_data == 8'h0A |-> last_q == 8'h0D)
    else $error("line feed without carriage return");
  body_chars_a: assert property (rsp_hs && pos_q != 5'h00 && rsp_data != 8'h0D
    && rsp_data != 8'h0A |-> (rsp_data inside {[8'h30:8'h39], 8'h2B, 8'h2D}))
    else $error("reply body char not digit or sign");
  line_len_a: assert property (rsp_hs |-> pos_q < 5'h10)
    else $error("reply line too long");
  mid_quiet_a: assert property (mid_q |-> !rsp_valid)
    else $error("reply sent while command incomplete");
endmodule : sdi12_link_sva

/* testbench/sdi12_sensor_command_handler_tb.sv */
// Self-checking bench joining the sensor and logger command ends
`timescale 1ns/100ps
module sdi12_sensor_command_handler_tb;
  logic sys_clk;
  logic rst;
  logic [7:0] cmd_byte;
  logic cmd_byte_valid;
  logic brk_req;
  logic [31:0] sample_in;
  logic [7:0] addr_out;
  logic busy_out;
  logic [7:0] rsp_byte;
  logic rsp_byte_valid;
  logic line_done;
  logic [7:0] got [$];
  int failures;
  int checks_done;
  sdi12_link_if link();
  sdi12_sensor_end #(.SEC_CYCLES(10), .NVAL(2), .MEAS_SEC(3), .FIFO_DEPTH(16))
    u_sdi12_sensor_end (.sys_clk(sys_clk), .rst(rst), .link(link.sensor),
    .sample_in(sample_in), .addr_out(addr_out), .busy_out(busy_out));
  sdi12_logger_end u_sdi12_logger_end (.sys_clk(sys_clk), .rst(rst), .link(link.logger),
    .cmd_byte(cmd_byte), .cmd_byte_valid(cmd_byte_valid), .cmd_byte_ready(),
    .brk_req(brk_req), .rsp_byte(rsp_byte), .rsp_byte_valid(rsp_byte_valid),
    .line_done(line_done));
  sdi12_link_sva u_sdi12_link_sva (.sys_clk(sys_clk), .rst(rst), .cmd_data(link.cmd_data),
    .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .rsp_data(link.rsp_data),
    .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready), .brk(link.brk));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // Collects reply chars until the logger flags the end of a line
  task automatic collect(input int lim);
    int n;
    n = 0;
    got.delete();
    while (n < lim) begin
      // Registered logger outputs are settled mid-cycle
      @(negedge sys_clk);
      n++;
      if (rsp_byte_valid === 1'b1) got.push_back(rsp_byte);
      if (line_done === 1'b1) break;
    end
  endtask : collect
  task automatic xfer(input string s, input int lim);
    int n;
    @(posedge sys_clk);
    for (int i = 0; i < s.len(); i++) begin
      cmd_byte <= s[i];
      cmd_byte_valid <= 1'b1;
      n = 0;
      // Ready only moves on the rising edge, so look at it mid-cycle
      do begin
        @(negedge sys_clk);
        n++;
      end while (link.cmd_ready !== 1'b1 && n < 50);
      if (link.cmd_ready !== 1'b1) begin
        failures++;
        finish_test();
      end
      @(posedge sys_clk);
    end
    cmd_byte_valid <= 1'b0;
    collect(lim);
  endtask : xfer
  // A dot in the expected line matches any char
  task automatic expect_line(input string s);
    check(8'(got.size()), 8'(s.len()));
    for (int i = 0; i < s.len(); i++) begin
      if (s[i] != ".") check(i < got.size() ? got[i] : 8'h00, s[i]);
    end
  endtask : expect_line
  task automatic t_measure();
    xfer("0M!", 40);
    expect_line("00032\015\012");
    collect(200);
    expect_line("0\015\012");
    xfer("0D0!", 40);
    expect_line("0++\015\012");
    $display("measure test done");
  endtask : t_measure
  task automatic t_break();
    xfer("0M!", 40);
    expect_line("00032\015\012");
    @(posedge sys_clk);
    brk_req <= 1'b1;
    repeat (4) @(posedge sys_clk);
    brk_req <= 1'b0;
    collect(100);
    check(8'(got.size()), 8'h00);
    check({7'h00, busy_out}, 8'h00);
    $display("break test done");
  endtask : t_break
  task automatic t_conc();
    @(posedge sys_clk);
    sample_in <= 32'h8001_8002;
    xfer("0C!", 40);
    expect_line("000302\015\012");
    check({7'h00, busy_out}, 8'h01);
    collect(100);
    check(8'(got.size()), 8'h00);
    xfer("0D0!", 40);
    expect_line("0--\015\012");
    xfer("0C!", 40);
    xfer("0!", 40);
    expect_line("0\015\012");
    check({7'h00, busy_out}, 8'h00);
    $display("concurrent test done");
  endtask : t_conc
  task automatic t_address();
    xfer("5M!", 40);
    check(8'(got.size()), 8'h00);
    check({7'h00, busy_out}, 8'h00);
    xfer("0A2!", 40);
    expect_line("2\015\012");
    check(addr_out, 8'h32);
    xfer("?!", 40);
    expect_line("2\015\012");
    xfer("2V!", 40);
    expect_line("2...0\015\012");
    $display("address test done");
  endtask : t_address
  initial begin
    rst = 1'b1;
    cmd_byte = 8'h00;
    cmd_byte_valid = 1'b0;
    brk_req = 1'b0;
    sample_in = 32'h0001_0002;
    failures = 0;
    checks_done = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check(addr_out, 8'h30);
    xfer("?!", 40);
    expect_line("0\015\012");
    t_measure();
    t_break();
    t_conc();
    t_address();
    finish_test();
  end
  initial begin
    #500000;
    failures++;
    finish_test();
  end
endmodule : sdi12_sensor_command_handler_tb
